/* File: hdl/charger_status_fault_regs.v */
/*
  Status and fault register bank of a single-cell battery charger:
  four 8-bit registers read by the serial register engine, two interrupt
  mask bits, a self-clearing register reset bit and constant identity.
  Assumes a serial register engine in front of it that issues one-cycle
  read and write strobes with an 8-bit register address, and analog
  detectors whose flags arrive asynchronously to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "charger_status_fault_regs.vh"

module charger_status_fault_regs #(
  parameter       FULL_DETECT      = 1,     // 1 full detection, 0 basic
  parameter [3:0] PART_IDENTIFIER  = 4'ha,  // Arbitrary value
  parameter [0:0] PART_FLAG        = 1'h1,  // Arbitrary value
  parameter [1:0] REVISION_FIELD   = 2'h2   // Arbitrary value
) (
  // Clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // Register port from the serial engine
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  // Source detection
  input  wire [2:0] detected_source,
  input  wire       source_select,
  input  wire       otg_active,
  // Charger state
  input  wire [1:0] charge_phase,
  input  wire       power_good,
  input  wire       thermal_reg_active,
  input  wire       min_sys_voltage_active,
  // Fault detectors
  input  wire       watchdog_expired,
  input  wire       boost_overload,
  input  wire       boost_output_overvolt,
  input  wire       boost_battery_low,
  input  wire       input_overvolt,
  input  wire       input_below_limit,
  input  wire       thermal_shutdown,
  input  wire       safety_timer_expired,
  input  wire       battery_overvolt,
  input  wire [2:0] thermistor_condition,
  input  wire       buck_mode,
  // Input regulation state
  input  wire       input_attached,
  input  wire       input_voltage_limit,
  input  wire       input_current_limit,
  input  wire       topoff_counting,
  input  wire       adaptor_overvolt,
  // Events to the rest of the charger
  output reg        irq_pulse,
  output reg        settings_default,
  output reg        safety_timer_clear
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------

  wire [`SYNC_W-1:0] raw_in;
  reg  [`SYNC_W-1:0] sync_a;
  reg  [`SYNC_W-1:0] sync_b;
  reg  [`SYNC_W-1:0] sync_c;
  reg  [`SYNC_W-1:0] held;

  // All detector flags gathered into one vector
  assign raw_in = {detected_source, source_select, otg_active,
                   charge_phase, power_good, thermal_reg_active,
                   min_sys_voltage_active, watchdog_expired,
                   boost_overload, boost_output_overvolt, boost_battery_low,
                   input_overvolt, input_below_limit, thermal_shutdown,
                   safety_timer_expired, battery_overvolt,
                   thermistor_condition, buck_mode, input_attached,
                   input_voltage_limit, input_current_limit,
                   topoff_counting, adaptor_overvolt};

  // Three stages; a bit changes once the second and third agree
  genvar gi;
  generate
    for (gi = 0; gi < `SYNC_W; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
          held[gi]   <= 1'b0;
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
          if (sync_b[gi] == sync_c[gi]) begin
            held[gi] <= sync_c[gi];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Unpacked filtered flags
  // ----------------------------------------------------------------

  wire [2:0] s_source;
  wire       s_select;
  wire       s_otg;
  wire [1:0] s_phase;
  wire       s_pgood;
  wire       s_therm_reg;
  wire       s_min_sys;
  wire       s_wdog;
  wire       s_b_overload;
  wire       s_b_ovp;
  wire       s_b_batlow;
  wire       s_in_ovp;
  wire       s_in_low;
  wire       s_tshut;
  wire       s_tmr_exp;
  wire       s_bat_ovp;
  wire [2:0] s_ntc;
  wire       s_buck;
  wire       s_attached;
  wire       s_vlim;
  wire       s_ilim;
  wire       s_topoff;
  wire       s_adapt_ovp;

  // Same order as the gathered vector
  assign {s_source, s_select, s_otg, s_phase, s_pgood, s_therm_reg,
          s_min_sys, s_wdog, s_b_overload, s_b_ovp, s_b_batlow,
          s_in_ovp, s_in_low, s_tshut, s_tmr_exp, s_bat_ovp,
          s_ntc, s_buck, s_attached, s_vlim, s_ilim,
          s_topoff, s_adapt_ovp} = held;

  // ----------------------------------------------------------------
  // Source type encoding
  // ----------------------------------------------------------------

  reg [2:0] source_type;

  // Full variant passes legal codes, basic variant builds its own
  always @* begin
    source_type = `SRC_NONE;
    if (FULL_DETECT != 0) begin
      case (s_source)
        `SRC_SDP, `SRC_CDP, `SRC_DCP,
        `SRC_UNKNOWN, `SRC_NONSTD, `SRC_OTG: begin
          source_type = s_source;
        end
        default: begin
          source_type = `SRC_NONE;
        end
      endcase
    end else begin
      if (s_otg) begin
        source_type = `SRC_OTG;
      end else if (!s_attached) begin
        source_type = `SRC_NONE;
      end else if (s_select) begin
        source_type = `SRC_HOST_PORT;
      end else begin
        source_type = `SRC_ADAPTOR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Charge error and thermistor encoding
  // ----------------------------------------------------------------

  reg [1:0] charge_error;
  reg [2:0] ntc_code;

  // Thermal shutdown outranks input fault, which outranks timer expiry
  always @* begin
    if (s_tshut) begin
      charge_error = `CERR_THERMAL;
    end else if (s_in_ovp || s_in_low) begin
      charge_error = `CERR_INPUT;
    end else if (s_tmr_exp) begin
      charge_error = `CERR_TIMER;
    end else begin
      charge_error = `CERR_NORMAL;
    end
  end

  // Live condition; warm and cool only shown in buck operation
  always @* begin
    case (s_ntc)
      `NTC_COLD: begin
        ntc_code = `NTC_COLD;
      end
      `NTC_HOT: begin
        ntc_code = `NTC_HOT;
      end
      `NTC_WARM: begin
        ntc_code = s_buck ? `NTC_WARM : `NTC_NORMAL;
      end
      `NTC_COOL: begin
        ntc_code = s_buck ? `NTC_COOL : `NTC_NORMAL;
      end
      default: begin
        ntc_code = `NTC_NORMAL;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------

  reg  voltage_limit_irq_mask;
  reg  current_limit_irq_mask;
  reg  reg_reset_bit;

  wire [7:0] img_charger;
  wire [7:0] img_fault;
  wire [7:0] img_input;
  wire [7:0] img_ident;

  // Charger status word
  assign img_charger = {source_type,
                        s_phase,
                        s_pgood,
                        s_therm_reg,
                        s_min_sys};

  // Fault word
  assign img_fault = {s_wdog,
                      s_b_overload | s_b_ovp | s_b_batlow,
                      charge_error,
                      s_bat_ovp,
                      ntc_code};

  // Input regulation word, bit 4 reserved as zero
  assign img_input = {s_attached,
                      s_vlim,
                      s_ilim,
                      1'b0,
                      s_topoff,
                      s_adapt_ovp,
                      voltage_limit_irq_mask,
                      current_limit_irq_mask};

  // Reset bit and constant identity
  assign img_ident = {reg_reset_bit, PART_IDENTIFIER, PART_FLAG, REVISION_FIELD};

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  wire wr_input;
  wire wr_ident;

  assign wr_input = reg_wr && (reg_addr == `OFS_INPUT_REGULATION_STATUS);
  assign wr_ident = reg_wr && (reg_addr == `OFS_RESET_AND_IDENTITY);

  // Mask bits; a register reset returns them to default
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      voltage_limit_irq_mask <= `RST_MASK;
      current_limit_irq_mask <= `RST_MASK;
    end else if (reg_reset_bit) begin
      voltage_limit_irq_mask <= `RST_MASK;
      current_limit_irq_mask <= `RST_MASK;
    end else if (wr_input) begin
      voltage_limit_irq_mask <= reg_wdata[`POS_VOLT_MASK];
      current_limit_irq_mask <= reg_wdata[`POS_CURR_MASK];
    end
  end

  // Reset bit stands one cycle, then clears itself
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_reset_bit      <= 1'b0;
      settings_default   <= 1'b0;
      safety_timer_clear <= 1'b0;
    end else begin
      reg_reset_bit      <= wr_ident && reg_wdata[`POS_REG_RESET] && !reg_reset_bit;
      settings_default   <= wr_ident && reg_wdata[`POS_REG_RESET] && !reg_reset_bit;
      safety_timer_clear <= wr_ident && reg_wdata[`POS_REG_RESET] && !reg_reset_bit;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------

  reg [7:0] next_rdata;

  // Address decode of the read image
  always @* begin
    case (reg_addr)
      `OFS_CHARGER_STATUS: begin
        next_rdata = img_charger;
      end
      `OFS_FAULT_STATUS: begin
        next_rdata = img_fault;
      end
      `OFS_INPUT_REGULATION_STATUS: begin
        next_rdata = img_input;
      end
      `OFS_RESET_AND_IDENTITY: begin
        next_rdata = img_ident;
      end
      default: begin
        next_rdata = `RDATA_UNMAPPED;
      end
    endcase
  end

  // Read data lands one cycle after the strobe; reads have no side effect
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Regulation event pulses
  // ----------------------------------------------------------------

  reg vlim_d;
  reg ilim_d;

  // Rising edge of a limit flag gives a pulse unless masked
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      vlim_d    <= 1'b0;
      ilim_d    <= 1'b0;
      irq_pulse <= 1'b0;
    end else begin
      vlim_d    <= s_vlim;
      ilim_d    <= s_ilim;
      irq_pulse <= (s_vlim && !vlim_d && !voltage_limit_irq_mask) ||
                   (s_ilim && !ilim_d && !current_limit_irq_mask);
    end
  end

endmodule // charger_status_fault_regs

`default_nettype wire

/* File: hdl/charger_status_fault_regs.vh */
/*
  Register offsets, field positions, field codes and reset values of the
  charger status and fault register bank.
  Assumes it is included by its bare name from the design file.
*/
`ifndef CHARGER_STATUS_FAULT_REGS_VH
`define CHARGER_STATUS_FAULT_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CHARGER_STATUS          8'h08
`define OFS_FAULT_STATUS            8'h09
`define OFS_INPUT_REGULATION_STATUS 8'h0a
`define OFS_RESET_AND_IDENTITY      8'h0b

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define POS_VOLT_MASK               1
`define POS_CURR_MASK               0
`define POS_REG_RESET               7

// ----------------------------------------------------------------
// Source type codes
// ----------------------------------------------------------------
`define SRC_NONE                    3'h0
`define SRC_SDP                     3'h1
`define SRC_CDP                     3'h2
`define SRC_DCP                     3'h3
`define SRC_UNKNOWN                 3'h5
`define SRC_NONSTD                  3'h6
`define SRC_OTG                     3'h7
`define SRC_HOST_PORT               3'h1
`define SRC_ADAPTOR                 3'h2

// ----------------------------------------------------------------
// Charge error codes
// ----------------------------------------------------------------
`define CERR_NORMAL                 2'h0
`define CERR_INPUT                  2'h1
`define CERR_THERMAL                2'h2
`define CERR_TIMER                  2'h3

// ----------------------------------------------------------------
// Thermistor condition codes
// ----------------------------------------------------------------
`define NTC_NORMAL                  3'h0
`define NTC_WARM                    3'h2
`define NTC_COOL                    3'h3
`define NTC_COLD                    3'h5
`define NTC_HOT                     3'h6

// ----------------------------------------------------------------
// Reset values and read answers
// ----------------------------------------------------------------
`define RST_MASK                    1'h0
`define RDATA_UNMAPPED              8'h00

// ----------------------------------------------------------------
// Input synchroniser width (all status inputs together)
// ----------------------------------------------------------------
`define SYNC_W                      28

`endif

/* File: dv/charger_status_fault_regs_sva.sv */
/*
  Concurrent checks on the charger status and fault register bank.
  Assumes it is bound to the bank's top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module charger_status_fault_regs_sva #(
  parameter       FULL_DETECT     = 1,     // 1 full detection, 0 basic
  parameter [3:0] PART_IDENTIFIER = 4'ha,  // Arbitrary value
  parameter [0:0] PART_FLAG       = 1'h1,  // Arbitrary value
  parameter [1:0] REVISION_FIELD  = 2'h2   // Arbitrary value
) (
  // Clock, reset and register port
  input wire       sys_clk, rst_n, reg_wr, reg_rd, settings_default, safety_timer_clear,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata,
  // Status inputs
  input wire [2:0] detected_source, thermistor_condition,
  input wire [1:0] charge_phase,
  input wire       power_good, thermal_reg_active, min_sys_voltage_active, watchdog_expired,
  input wire       boost_overload, boost_output_overvolt, boost_battery_low, input_overvolt,
  input wire       input_below_limit, thermal_shutdown, safety_timer_expired, battery_overvolt,
  input wire       buck_mode, input_attached, input_voltage_limit, input_current_limit,
  input wire       topoff_counting, adaptor_overvolt, irq_pulse, source_select, otg_active
);
  // ----------------------------------------------------------------
  // Expected read images
  // ----------------------------------------------------------------
  wire [27:0] st = {source_select, otg_active, detected_source, thermistor_condition, charge_phase, power_good,
    thermal_reg_active,
    min_sys_voltage_active, watchdog_expired, boost_overload, boost_output_overvolt, boost_battery_low,
    input_overvolt, input_below_limit, thermal_shutdown, safety_timer_expired, battery_overvolt, buck_mode,
    input_attached, input_voltage_limit, input_current_limit, topoff_counting, adaptor_overvolt};
  wire [2:0]  ntc_exp = (thermistor_condition == 3'h5 || thermistor_condition == 3'h6 ||
    (buck_mode && (thermistor_condition == 3'h2 || thermistor_condition == 3'h3))) ? thermistor_condition : 3'h0;
  wire [1:0]  cerr_exp = thermal_shutdown ? 2'h2 : (input_overvolt | input_below_limit) ? 2'h1 :
    safety_timer_expired ? 2'h3 : 2'h0;
  // Source code: reserved full code reads none; basic variant built from pins
  wire [2:0]  src_exp = FULL_DETECT ? ((detected_source == 3'h4) ? 3'h0 : detected_source) :
    otg_active ? 3'h7 : !input_attached ? 3'h0 : source_select ? 3'h1 : 3'h2;
  reg  [27:0] st_q;
  reg  [2:0]  qc;
  reg  [7:0]  e8, e9, ea;

  // Edges since the inputs last moved, and images one cycle late
  always @(posedge sys_clk) begin
    st_q <= st;
    if (!rst_n || st != st_q) qc <= 3'h0;
    else if (qc != 3'h7) qc <= qc + 3'h1;
    e8 <= {src_exp, charge_phase, power_good,
      thermal_reg_active, min_sys_voltage_active};
    e9 <= {watchdog_expired, boost_overload | boost_output_overvolt | boost_battery_low, cerr_exp,
      battery_overvolt, ntc_exp};
    ea <= {input_attached, input_voltage_limit, input_current_limit, 1'b0, topoff_counting,
      adaptor_overvolt, 2'h0};
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Read of a settled status register
  sequence rd_q(a);
    qc >= 3'h6 && reg_rd && reg_addr == a;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_source_code: assert property (rd_q(8'h08) |=> reg_rdata[7:5] == e8[7:5])
    else $error("source code wrong");
  a_status_bits: assert property (rd_q(8'h08) |=> reg_rdata[4:0] == e8[4:0])
    else $error("charger status bits wrong");
  a_fault_flags: assert property (rd_q(8'h09) |=> reg_rdata[7:6] == e9[7:6] && reg_rdata[3] == e9[3])
    else $error("fault flags wrong");
  a_charge_error: assert property (rd_q(8'h09) |=> reg_rdata[5:4] == e9[5:4])
    else $error("charge error code wrong");
  a_thermistor_live: assert property (rd_q(8'h09) |=> reg_rdata[2:0] == e9[2:0])
    else $error("thermistor code wrong");
  a_input_status: assert property (rd_q(8'h0a) |=> reg_rdata[7:2] == ea[7:2])
    else $error("input status bits wrong");
  a_ident_const: assert property (reg_rd && reg_addr == 8'h0b |=>
    reg_rdata[6:0] == {PART_IDENTIFIER, PART_FLAG, REVISION_FIELD})
    else $error("identity fields wrong");
  a_reset_pulse: assert property (reg_wr && reg_addr == 8'h0b && reg_wdata[7] && !settings_default |=>
    settings_default ##1 !settings_default)
    else $error("register reset pulse wrong");
  a_reset_zero: assert property (reg_wr && reg_addr == 8'h0b && !reg_wdata[7] |=> !settings_default)
    else $error("writing zero caused a reset");
  a_timer_paired: assert property (settings_default == safety_timer_clear)
    else $error("safety timer clear not paired");
  a_mask_default: assert property (settings_default ##1 (reg_rd && reg_addr == 8'h0a) |=>
    reg_rdata[1:0] == 2'h0)
    else $error("masks not back to default");

  // Main scenarios reached
  c_reg_reset: cover property (settings_default);
  c_irq: cover property (irq_pulse);
  c_fault_read: cover property (rd_q(8'h09));
endmodule // charger_status_fault_regs_sva

bind charger_status_fault_regs charger_status_fault_regs_sva #(.FULL_DETECT(FULL_DETECT),
  .PART_IDENTIFIER(PART_IDENTIFIER),
  .PART_FLAG(PART_FLAG), .REVISION_FIELD(REVISION_FIELD)) charger_status_fault_regs_sva_inst (.*);
`default_nettype wire

/* File: dv/host_model.sv */
/*
  Host processor model: one-cycle read and write strobes on the register port.
  Assumes the bench calls its tasks; requests change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock and answer
  input  wire       sys_clk,
  input  wire [7:0] reg_rdata,
  input  wire       reg_rvalid,
  // Requests
  output reg  [7:0] reg_addr,
  output reg        reg_wr,
  output reg  [7:0] reg_wdata,
  output reg        reg_rd
);
  // Idle lines at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Write strobe for one edge, then scramble the released lines
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
    end
  endtask

  // Read strobe for one edge; answer taken one cycle later
  task rd(input [7:0] a, output [7:0] d, output ok);
    begin
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      ok = reg_rvalid;
      d = reg_rdata;
    end
  endtask
endmodule // host_model
`default_nettype wire

/* File: dv/test_charger_status_fault_regs.sv */
/*
  Self-checking bench of the charger status and fault register bank.
  Assumes the host model on the register port and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_charger_status_fault_regs;
  reg        sys_clk, rst_n, source_select, otg_active, power_good, thermal_reg_active, min_sys_voltage_active;
  reg        watchdog_expired, boost_overload, boost_output_overvolt, boost_battery_low, input_overvolt;
  reg        input_below_limit, thermal_shutdown, safety_timer_expired, battery_overvolt, buck_mode;
  reg        input_attached, input_voltage_limit, input_current_limit, topoff_counting, adaptor_overvolt;
  reg  [2:0] detected_source, thermistor_condition;
  reg  [1:0] charge_phase;
  wire [7:0] reg_addr, reg_wdata, reg_rdata, b_rdata;
  wire       reg_wr, reg_rd, reg_rvalid, irq_pulse, settings_default, safety_timer_clear;
  integer    n_errors, checks_done, n_irq, n_def, n_tmr;

  charger_status_fault_regs charger_status_fault_regs_inst (.*);
  // Basic source-detection variant on the same pins and strobes
  charger_status_fault_regs #(.FULL_DETECT(0)) charger_status_fault_regs_basic_inst (.*, .reg_rdata(b_rdata),
    .reg_rvalid(), .irq_pulse(), .settings_default(), .safety_timer_clear());
  host_model host_model_inst (.*);

  // Clock and event pulse counters
  always #5 sys_clk = ~sys_clk;
  // Outputs are unknown before the first reset edge, so count only out of reset
  always @(posedge sys_clk) begin
    if (rst_n) begin
      n_irq <= n_irq + irq_pulse;
      n_def <= n_def + settings_default;
      n_tmr <= n_tmr + safety_timer_clear;
    end
  end

  task chk(input [8*12-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task rdc(input [7:0] a, input [7:0] exp);
    reg [7:0] d;
    reg       ok;
    begin
      host_model_inst.rd(a, d, ok);
      chk("answer", 8'h01, {7'h0, ok});
      chk("read data", exp, d);
    end
  endtask

  // Status inputs as a function of a code and the buck mode
  task set_pins(input [2:0] i, input b);
    begin
      detected_source = i; thermistor_condition = i; charge_phase = i[1:0]; buck_mode = b;
      power_good = i[0]; thermal_reg_active = i[1]; min_sys_voltage_active = i[2]; watchdog_expired = i[0];
      boost_overload = i == 3'h1; boost_output_overvolt = i == 3'h2; boost_battery_low = i == 3'h4;
      input_overvolt = i[0] & ~i[1]; input_below_limit = i[0] & i[1]; thermal_shutdown = i[2];
      safety_timer_expired = i[1]; battery_overvolt = i[1]; input_attached = i[0]; topoff_counting = i[2];
      input_voltage_limit = i[0] & i[1]; input_current_limit = i[1]; adaptor_overvolt = i[0] ^ i[1];
      source_select = i[2]; otg_active = i == 3'h7;
    end
  endtask

  // Identity, writes to read-only places, unmapped read
  task t_ident;
    begin
      host_model_inst.wr(8'h0b, 8'h7f);
      rdc(8'h0b, 8'h56);
      host_model_inst.wr(8'h09, 8'hff);
      rdc(8'h09, 8'h00);
      rdc(8'h3c, 8'h00);
    end
  endtask

  // Every code of every status field, read back twice where live
  task t_status;
    integer   j;
    reg [2:0] i, ntc;
    reg [7:0] e9;
    begin
      for (j = 0; j < 16; j = j + 1) begin
        i = j[2:0];
        set_pins(i, j[3]);
        repeat (8) @(negedge sys_clk);
        ntc = (i == 3'h5 || i == 3'h6 || (j[3] && (i == 3'h2 || i == 3'h3))) ? i : 3'h0;
        e9 = {i[0], i == 3'h1 || i == 3'h2 || i == 3'h4, i[2] ? 2'h2 : i[0] ? 2'h1 : i[1] ? 2'h3 : 2'h0, i[1], ntc};
        rdc(8'h08, {(i == 3'h4) ? 3'h0 : i, i[1:0], i[0], i[1], i[2]});
        chk("basic source", {5'h0, (i == 3'h7) ? 3'h7 : !i[0] ? 3'h0 : i[2] ? 3'h1 : 3'h2}, {5'h0, b_rdata[7:5]});
        rdc(8'h09, e9);
        rdc(8'h09, e9);
        rdc(8'h0a, {i[0], i[0] & i[1], i[1], 1'b0, i[2], i[0] ^ i[1], 2'h0});
      end
    end
  endtask

  // Masked and unmasked events, then register reset
  task t_irq;
    integer n0;
    begin
      set_pins(3'h0, 1'b0);
      repeat (8) @(negedge sys_clk);
      host_model_inst.wr(8'h0a, 8'hff);
      rdc(8'h0a, 8'h03);
      n0 = n_irq;
      input_voltage_limit = 1'b1;
      repeat (8) @(negedge sys_clk);
      input_current_limit = 1'b1;
      repeat (8) @(negedge sys_clk);
      chk("masked irq", n0[7:0], n_irq[7:0]);
      input_voltage_limit = 1'b0;
      input_current_limit = 1'b0;
      host_model_inst.wr(8'h0a, 8'h00);
      repeat (8) @(negedge sys_clk);
      input_voltage_limit = 1'b1;
      repeat (8) @(negedge sys_clk);
      chk("volt irq", n0[7:0] + 8'h01, n_irq[7:0]);
      input_current_limit = 1'b1;
      repeat (8) @(negedge sys_clk);
      chk("curr irq", n0[7:0] + 8'h02, n_irq[7:0]);
      n0 = n_def;
      host_model_inst.wr(8'h0a, 8'h03);
      host_model_inst.wr(8'h0b, 8'h80);
      // Masks take their defaults one edge after the reset pulse
      @(negedge sys_clk);
      rdc(8'h0a, 8'h60);
      chk("defaults", n0[7:0] + 8'h01, n_def[7:0]);
      chk("timer clear", n_def[7:0], n_tmr[7:0]);
      host_model_inst.wr(8'h0b, 8'h00);
      rdc(8'h0b, 8'h56);
      chk("defaults", n0[7:0] + 8'h01, n_def[7:0]);
    end
  endtask

  task test_done;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    n_errors = 0;
    checks_done = 0;
    n_irq = 0;
    n_def = 0;
    n_tmr = 0;
    set_pins(3'h0, 1'b0);
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_ident;
    t_status;
    t_irq;
    test_done;
  end

  // Watchdog against a hang
  initial begin
    #100000;
    n_errors = n_errors + 1;
    test_done;
  end
endmodule // test_charger_status_fault_regs
`default_nettype wire
